/* core/tfc_pkg.sv */
package tfc_pkg;
   localparam int TFC_TEMP_W = 12;
   localparam int TFC_SPD_W = 8;
   localparam int TFC_TMR_W = 16;
   // minimum times in seconds, timer tick is one second
   localparam int TFC_CLK_HZ = 10_000_000;
   localparam int TFC_TICK_CYC = TFC_CLK_HZ;
   localparam logic [TFC_TMR_W-1:0] TFC_CAB_MIN_S_RST = 16'h003c;
   localparam logic [TFC_TMR_W-1:0] TFC_STK_MIN_S_RST = 16'h003c;

   typedef enum logic [1:0]
   {
      TFC_CAB_FAST = 2'b00,
      TFC_CAB_SLOW = 2'b01,
      TFC_CAB_OFF = 2'b11
   } tfc_cab_st_t;

   typedef enum logic [1:0]
   {
      TFC_STK_MAX = 2'b00,
      TFC_STK_VAR = 2'b01,
      TFC_STK_OFF = 2'b11
   } tfc_stk_st_t;

   typedef struct packed
   {
      logic [TFC_TEMP_W-1:0] t_on;
      logic [TFC_TEMP_W-1:0] t_off;
      logic [TFC_TEMP_W-1:0] t_fast;
      logic [TFC_TEMP_W-1:0] t_slow;
      logic [TFC_TMR_W-1:0] min_s;
   } tfc_cab_cfg_t;

   typedef struct packed
   {
      logic [TFC_TEMP_W-1:0] t_off;
      logic [TFC_TEMP_W-1:0] t_on;
      logic [TFC_TEMP_W-1:0] x_lo;
      logic [TFC_TEMP_W-1:0] x_hi;
      logic [TFC_SPD_W-1:0] y_lo;
      logic [TFC_SPD_W-1:0] y_hi;
      logic [TFC_TMR_W-1:0] min_s;
   } tfc_stk_cfg_t;
endpackage

/* core/tfc_interp.sv */
`timescale 1ns/100ps
// combinational linear characteristic with clamping
module tfc_interp
   import tfc_pkg::*;
#(
   parameter int TW = TFC_TEMP_W,
   parameter int SW = TFC_SPD_W
)
(
   // characteristic
   input wire logic [TW-1:0] i_x_lo,
   input wire logic [TW-1:0] i_x_hi,
   input wire logic [SW-1:0] i_y_lo,
   input wire logic [SW-1:0] i_y_hi,
   // sample
   input wire logic [TW-1:0] i_x,
   output logic [SW-1:0] o_y
);
   // elaboration-time refusal of widths the divider cannot serve
   if (TW < 2 || SW < 2)
      $error("tfc_interp: widths too small");

   logic [TW-1:0] dx;
   logic [TW-1:0] span;
   logic signed [SW:0] dy;
   logic signed [TW+SW+1:0] prod;
   logic signed [TW+SW+1:0] quo;

   always_comb
   begin
      dx = '0;
      span = i_x_hi - i_x_lo;
      dy = $signed({1'b0, i_y_hi}) - $signed({1'b0, i_y_lo});
      prod = '0;
      quo = '0;
      if (i_x <= i_x_lo || span == '0)
         o_y = i_y_lo;
      else if (i_x >= i_x_hi)
         o_y = i_y_hi;
      else
      begin
         dx = i_x - i_x_lo;
         prod = $signed({2'b00, dx}) * dy;
         quo = prod / $signed({{(SW+2){1'b0}}, span});
         o_y = SW'(quo + $signed({{(TW+2){1'b0}}, i_y_lo}));
      end
   end
endmodule

/* core/tfc_top.sv */
`timescale 1ns/100ps
module tfc_top
   import tfc_pkg::*;
#(
   parameter int TICK_CYC = TFC_TICK_CYC
)
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // control module restart, one-cycle pulse
   input wire logic i_restart,
   // temperature samples
   input wire logic [TFC_TEMP_W-1:0] i_exh_t0,
   input wire logic [TFC_TEMP_W-1:0] i_exh_t1,
   input wire logic [TFC_TEMP_W-1:0] i_stk_t0,
   input wire logic [TFC_TEMP_W-1:0] i_stk_t1,
   // thresholds
   input wire tfc_cab_cfg_t i_cab_cfg,
   input wire tfc_stk_cfg_t i_stk_cfg,
   // cabinet fan
   output logic o_cab_slow,
   output logic o_cab_fast,
   // stack fan
   output logic o_stk_on,
   output logic [TFC_SPD_W-1:0] o_stk_speed
);
   // elaboration-time refusal of a tick divider that cannot count
   if (TICK_CYC < 1)
      $error("tfc_top: TICK_CYC must be positive");

   localparam logic [31:0] TICK_LAST = 32'(TICK_CYC - 1);
   localparam logic [TFC_SPD_W-1:0] SPD_MAX = '1;

   typedef struct packed
   {
      logic [31:0] div;
      logic tick;
      tfc_cab_st_t cab;
      logic [TFC_TMR_W-1:0] cab_tmr;
      tfc_stk_st_t stk;
      logic [TFC_TMR_W-1:0] stk_tmr;
      logic cab_slow;
      logic cab_fast;
      logic stk_on;
      logic [TFC_SPD_W-1:0] stk_speed;
   } tfc_state_t;

   tfc_state_t st_r;
   tfc_state_t st_nxt;

   logic [TFC_TEMP_W-1:0] exh_max;
   logic [TFC_TEMP_W-1:0] stk_max;
   logic [TFC_SPD_W-1:0] var_speed;
   logic cab_done;
   logic stk_done;

   ////////////////////////////////////////////////////////////////////////
   // hotter of each sensor pair
   assign exh_max = (i_exh_t0 > i_exh_t1) ? i_exh_t0 : i_exh_t1;
   assign stk_max = (i_stk_t0 > i_stk_t1) ? i_stk_t0 : i_stk_t1;

   assign cab_done = st_r.cab_tmr >= i_cab_cfg.min_s;
   assign stk_done = st_r.stk_tmr >= i_stk_cfg.min_s;

   tfc_interp #(
      .TW(TFC_TEMP_W),
      .SW(TFC_SPD_W)
   ) u_interp (
      .i_x_lo(i_stk_cfg.x_lo),
      .i_x_hi(i_stk_cfg.x_hi),
      .i_y_lo(i_stk_cfg.y_lo),
      .i_y_hi(i_stk_cfg.y_hi),
      .i_x(stk_max),
      .o_y(var_speed)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      st_nxt = st_r;
      // one-second tick
      st_nxt.tick = 1'b0;
      if (st_r.div >= TICK_LAST)
      begin
         st_nxt.div = '0;
         st_nxt.tick = 1'b1;
      end
      else
         st_nxt.div = st_r.div + 32'h0000_0001;

      if (st_r.tick && st_r.cab_tmr != '1)
         st_nxt.cab_tmr = st_r.cab_tmr + 16'h0001;
      if (st_r.tick && st_r.stk_tmr != '1)
         st_nxt.stk_tmr = st_r.stk_tmr + 16'h0001;

      // cabinet fan, three stages only
      case (st_r.cab)
         TFC_CAB_FAST:
         begin
            if (cab_done && exh_max < i_cab_cfg.t_slow)
               st_nxt.cab = TFC_CAB_SLOW;
         end
         TFC_CAB_SLOW:
         begin
            if (exh_max > i_cab_cfg.t_fast)
            begin
               st_nxt.cab = TFC_CAB_FAST;
               st_nxt.cab_tmr = '0;
            end
            else if (exh_max < i_cab_cfg.t_off)
               st_nxt.cab = TFC_CAB_OFF;
         end
         TFC_CAB_OFF:
         begin
            if (exh_max > i_cab_cfg.t_on)
            begin
               st_nxt.cab = TFC_CAB_FAST;
               st_nxt.cab_tmr = '0;
            end
         end
         default:
         begin
            st_nxt.cab = TFC_CAB_FAST;
            st_nxt.cab_tmr = '0;
         end
      endcase

      // stack fan, maximum, variable or off
      case (st_r.stk)
         TFC_STK_MAX:
         begin
            if (stk_done)
            begin
               if (stk_max < i_stk_cfg.t_off)
                  st_nxt.stk = TFC_STK_OFF;
               else
                  st_nxt.stk = TFC_STK_VAR;
            end
         end
         TFC_STK_VAR:
         begin
            if (stk_max < i_stk_cfg.t_off)
               st_nxt.stk = TFC_STK_OFF;
         end
         TFC_STK_OFF:
         begin
            if (stk_max > i_stk_cfg.t_on)
            begin
               st_nxt.stk = TFC_STK_MAX;
               st_nxt.stk_tmr = '0;
            end
         end
         default:
         begin
            st_nxt.stk = TFC_STK_MAX;
            st_nxt.stk_tmr = '0;
         end
      endcase

      // restart acts like power-up
      if (i_restart)
      begin
         st_nxt.cab = TFC_CAB_FAST;
         st_nxt.cab_tmr = '0;
         st_nxt.stk = TFC_STK_MAX;
         st_nxt.stk_tmr = '0;
      end

      // registered outputs follow the next state
      st_nxt.cab_fast = st_nxt.cab == TFC_CAB_FAST;
      st_nxt.cab_slow = st_nxt.cab == TFC_CAB_SLOW;
      st_nxt.stk_on = st_nxt.stk != TFC_STK_OFF;
      case (st_nxt.stk)
         TFC_STK_MAX: st_nxt.stk_speed = SPD_MAX;
         TFC_STK_VAR: st_nxt.stk_speed = var_speed;
         default: st_nxt.stk_speed = '0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         st_r <= '0;
         st_r.cab <= TFC_CAB_FAST;
         st_r.stk <= TFC_STK_MAX;
         st_r.cab_fast <= 1'b1;
         st_r.stk_on <= 1'b1;
         st_r.stk_speed <= SPD_MAX;
      end
      else
         st_r <= st_nxt;
   end

   assign o_cab_slow = st_r.cab_slow;
   assign o_cab_fast = st_r.cab_fast;
   assign o_stk_on = st_r.stk_on;
   assign o_stk_speed = st_r.stk_speed;
endmodule

/* sim/tfc_top_sva.sv */
`timescale 1ns/100ps
module tfc_top_sva
   import tfc_pkg::*;
#(
   parameter int TICK_CYC = TFC_TICK_CYC
)
(
   // watched ports
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic i_restart,
   input wire logic [TFC_TEMP_W-1:0] i_exh_t0,
   input wire logic [TFC_TEMP_W-1:0] i_exh_t1,
   input wire tfc_cab_cfg_t i_cab_cfg,
   input wire tfc_stk_cfg_t i_stk_cfg,
   input wire logic o_cab_slow,
   input wire logic o_cab_fast,
   input wire logic o_stk_on,
   input wire logic [TFC_SPD_W-1:0] o_stk_speed
);
   logic [TFC_TEMP_W-1:0] em;
   int cc_r;
   int sc_r;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   assign em = (i_exh_t0 > i_exh_t1) ? i_exh_t0 : i_exh_t1;
   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         cc_r <= 0;
         sc_r <= 0;
      end
      else
      begin
         cc_r <= o_cab_fast ? cc_r + 1 : 0;
         sc_r <= (o_stk_speed == 8'hff) ? sc_r + 1 : 0;
      end
   end
   ////////////////////////////////////////////////////////////////
   a_one_stage: assert property (!(o_cab_slow && o_cab_fast))
      else $error("both cabinet stages on");
   a_rst_max: assert property (i_restart |=> o_cab_fast && o_stk_speed == 8'hff)
      else $error("restart not at full cooling");
   a_off_direct: assert property (!(o_cab_slow || o_cab_fast) |=> !o_cab_slow)
      else $error("off went to slow");
   a_fast_dwell: assert property ($fell(o_cab_fast) |-> o_cab_slow && $past(em <
      i_cab_cfg.t_slow) && cc_r >= (i_cab_cfg.min_s - 1) * TICK_CYC - 1)
      else $error("fast left early or wrongly");
   a_slow_off: assert property ($fell(o_cab_slow) && !o_cab_fast |->
      $past(em < i_cab_cfg.t_off))
      else $error("slow to off without cause");
   a_slow_fast: assert property ($rose(o_cab_fast) && $past(o_cab_slow) |->
      $past(em > i_cab_cfg.t_fast || i_restart))
      else $error("slow to fast without cause");
   a_stk_zero: assert property (!o_stk_on |-> o_stk_speed == 8'h00)
      else $error("speed while off");
   a_stk_start: assert property ($rose(o_stk_on) |-> o_stk_speed == 8'hff)
      else $error("stack start not at max");
   a_stk_dwell: assert property ($past(o_stk_speed) == 8'hff && o_stk_speed != 8'hff
      && i_stk_cfg.y_hi != 8'hff |-> sc_r >= (i_stk_cfg.min_s - 1) * TICK_CYC - 1)
      else $error("max phase too short");
   cover property ($fell(o_cab_slow) && !o_cab_fast);
   cover property ($rose(o_cab_fast) && $past(o_cab_slow));
   cover property ($fell(o_stk_on));
endmodule
bind tfc_top tfc_top_sva #(.TICK_CYC(TICK_CYC)) u_sva (.*);

/* sim/tfc_sense_model.sv */
`timescale 1ns/100ps
// sensor pairs: one reads the setpoint, its twin reads 8 below
module tfc_sense_model
   import tfc_pkg::*;
(
   // pair swap and setpoints
   input wire logic i_swap,
   input wire logic [TFC_TEMP_W-1:0] i_exh,
   input wire logic [TFC_TEMP_W-1:0] i_stk,
   // readings
   output logic [TFC_TEMP_W-1:0] o_exh_t0,
   output logic [TFC_TEMP_W-1:0] o_exh_t1,
   output logic [TFC_TEMP_W-1:0] o_stk_t0,
   output logic [TFC_TEMP_W-1:0] o_stk_t1
);
   assign o_exh_t0 = i_swap ? i_exh : i_exh - 12'h008;
   assign o_exh_t1 = i_swap ? i_exh - 12'h008 : i_exh;
   assign o_stk_t0 = i_swap ? i_stk - 12'h008 : i_stk;
   assign o_stk_t1 = i_swap ? i_stk : i_stk - 12'h008;
endmodule

/* sim/tfc_top_tb.sv */
`timescale 1ns/100ps
module tfc_top_tb
   import tfc_pkg::*;
;
   logic clk = 0, rst_b = 0, rs = 0, sw = 0, os, of, on;
   logic [11:0] ct = 12'h1c2, st = 12'h258, e0, e1, s0, s1;
   logic [7:0] sp;
   tfc_cab_cfg_t cc = '{12'h258, 12'h190, 12'h2bc, 12'h1f4, 16'h0003};
   tfc_stk_cfg_t sc = '{12'h12c, 12'h15e, 12'h190, 12'h320, 8'h20, 8'he0, 16'h0002};
   int fails = 0, n_checks = 0, k;
   always #50 clk = ~clk;
   tfc_sense_model pm (.i_swap(sw), .i_exh(ct), .i_stk(st), .o_exh_t0(e0),
      .o_exh_t1(e1), .o_stk_t0(s0), .o_stk_t1(s1));
   tfc_top #(.TICK_CYC(4)) dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_restart(rs),
      .i_exh_t0(e0), .i_exh_t1(e1), .i_stk_t0(s0), .i_stk_t1(s1), .i_cab_cfg(cc),
      .i_stk_cfg(sc), .o_cab_slow(os), .o_cab_fast(of), .o_stk_on(on), .o_stk_speed(sp));
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      n_checks++;
      if (s !== e)
      begin
         fails++;
         $display("[ERR] %s exp %h seen %h", n, e, s);
      end
   endtask
   task wt(input logic s, input logic f);
      for (k = 0; k < 40 && {os, of} !== {s, f}; k++) @(negedge clk);
      chk("stage", {os, of}, {s, f});
   endtask
   task go(input int n);
      repeat (n) @(negedge clk);
   endtask
   task results;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   task t_boot;
      chk("fast", of, 1'b1);
      chk("speed", sp, 8'hff);
      wt(1'b1, 1'b0);
      chk("dwell", k >= 7 && k <= 15, 1'b1);
      go(4);
      chk("var", sp, 8'h80);
   endtask
   task t_cab;
      ct = 12'h2d0;
      wt(1'b0, 1'b1);
      chk("to fast", k <= 1, 1'b1);
      ct = 12'h1c2;
      wt(1'b1, 1'b0);
      ct = 12'h180;
      wt(1'b0, 1'b0);
      chk("to off", k <= 1, 1'b1);
      ct = 12'h258;
      go(3);
      chk("eq on", of, 1'b0);
      ct = 12'h268;
      wt(1'b0, 1'b1);
      chk("off fast", k <= 1, 1'b1);
   endtask
   task t_stk;
      st = 12'h3e8;
      go(2);
      chk("clamp", sp, 8'he0);
      sw = 1;
      st = 12'h1f4;
      go(2);
      chk("pair", sp, 8'h50);
      st = 12'h11e;
      go(2);
      chk("off", {on, sp}, 9'h000);
      st = 12'h15e;
      go(3);
      chk("eq on", on, 1'b0);
      st = 12'h190;
      go(2);
      chk("rearm", sp, 8'hff);
      go(12);
      chk("low", sp, 8'h20);
   endtask
   task t_rst;
      ct = 12'h1c2;
      wt(1'b1, 1'b0);
      rs = 1;
      go(1);
      rs = 0;
      chk("rs cab", {os, of}, 2'b01);
      chk("rs stk", sp, 8'hff);
   endtask
   initial
   begin
      #100000;
      fails++;
      results;
   end
   initial
   begin
      go(10);
      rst_b = 1;
      t_boot;
      t_cab;
      t_stk;
      t_rst;
      results;
   end
endmodule
